// file: iir_swap_pkg.sv
package iir_swap_pkg;

    // -----------------------------------------------------------------
    // Widths and sizes
    // -----------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 16;
    localparam int ACC_W = 36;
    localparam int RESULT_W = 24;
    localparam int TAPS = 32;
    localparam int TAP_IDX_W = 5;
    localparam int MAX_IIR_ORDER = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int HALF_W = 12;

    // -----------------------------------------------------------------
    // Reset values and selector positions
    // -----------------------------------------------------------------
    localparam logic [1:0] SEL_BIT7 = 2'h0;
    localparam logic [1:0] SEL_BIT11 = 2'h1;
    localparam logic [1:0] SEL_BIT15 = 2'h2;
    localparam logic [1:0] SEL_BIT20 = 2'h3;
    localparam logic [1:0] SEL_RESET = 2'h2;
    localparam logic BANK_RESET = 1'b0;
    localparam logic [TAP_IDX_W-1:0] TAP_LAST = 5'h1f;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic {
        RES_FEEDBACK,
        RES_OUTPUT
    } result_kind_type;

endpackage

// file: iir_link_if.sv
`timescale 1ns/1ps

interface iir_link_if;
    import iir_swap_pkg::*;

    // Coefficient load port.
    logic coef_we;
    logic coef_bank;
    logic [TAP_IDX_W-1:0] coef_addr;
    logic [COEF_W-1:0] coef_data;
    logic swap_en;
    logic [1:0] out_sel;
    // Sample input register write.
    logic sample_we;
    logic [SAMPLE_W-1:0] sample_data;
    // Result words and handshake.
    logic result_valid;
    logic result_read;
    logic result_kind;
    logic [HALF_W-1:0] result_high_word;
    logic [HALF_W-1:0] result_low_word;
    logic busy;

    modport device (
        input coef_we, coef_bank, coef_addr, coef_data, swap_en, out_sel,
        input sample_we, sample_data, result_read,
        output result_valid, result_kind, result_high_word, result_low_word, busy
    );

    modport host (
        output coef_we, coef_bank, coef_addr, coef_data, swap_en, out_sel,
        output sample_we, sample_data, result_read,
        input result_valid, result_kind, result_high_word, result_low_word, busy
    );
endinterface

// file: iir_fifo.sv
`timescale 1ns/1ps

module iir_fifo
    import iir_swap_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // -----------------------------------------------------------------
    // Handshake
    // -----------------------------------------------------------------
    // Full and empty come straight from the occupancy count.
    assign o_in_ready = (count_r != DEPTH[AW:0]);
    assign o_out_valid = (count_r != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_r[rd_ptr_r];

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    // Entries are written at the write pointer only.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers wrap at the depth, which is a power of two.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: iir_mac_device.sv
`timescale 1ns/1ps

module iir_mac_device
    import iir_swap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    iir_link_if.device link
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MAC,
        ST_DONE
    } mac_state_type;

    mac_state_type state_r;
    logic signed [COEF_W-1:0] coef_r [2][TAPS];
    logic signed [SAMPLE_W-1:0] delay_r [TAPS];
    logic signed [ACC_W-1:0] acc_r;
    logic [TAP_IDX_W-1:0] tap_r;
    logic bank_r;
    logic swap_en_r;
    logic [1:0] sel_r;
    logic kind_r;
    logic valid_r;
    logic [RESULT_W-1:0] result_r;
    logic signed [ACC_W-1:0] prod;
    logic [RESULT_W-1:0] rounded;

    // -----------------------------------------------------------------
    // Coefficient memories and configuration
    // -----------------------------------------------------------------
    // Both banks are written by address; the host chooses the bank.
    always_ff @(posedge i_clk) begin
        if (link.coef_we) begin
            coef_r[link.coef_bank][link.coef_addr] <= link.coef_data;
        end
    end

    // Mode bits are latched only while idle so a computation never mixes modes.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            swap_en_r <= 1'b0;
            sel_r <= SEL_RESET;
        end else if (state_r == ST_IDLE) begin
            swap_en_r <= link.swap_en;
            sel_r <= link.out_sel;
        end
    end

    // -----------------------------------------------------------------
    // Sample delay line
    // -----------------------------------------------------------------
    // A sample write shifts the line by one, newest at tap zero.
    // Both passes of a raw sample shift the line, so the taps hold order 16 at most.
    genvar gi;
    generate
        for (gi = 0; gi < TAPS; gi++) begin : g_delay
            if (gi == 0) begin : g_head
                always_ff @(posedge i_clk) begin
                    if (!i_rst_b) begin
                        delay_r[gi] <= '0;
                    end else if (state_r == ST_IDLE && link.sample_we) begin
                        delay_r[gi] <= link.sample_data;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge i_clk) begin
                    if (!i_rst_b) begin
                        delay_r[gi] <= '0;
                    end else if (state_r == ST_IDLE && link.sample_we) begin
                        delay_r[gi] <= delay_r[gi-1];
                    end
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Multiply-accumulate sequencer
    // -----------------------------------------------------------------
    // One product per cycle, sign extended to the full accumulator width.
    assign prod = ACC_W'(coef_r[bank_r][tap_r] * delay_r[tap_r]);

    // The sequencer walks idle, all taps, then one publish cycle.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (link.sample_we) begin
                        state_r <= ST_MAC;
                    end
                end
                ST_MAC: begin
                    if (tap_r == TAP_LAST) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // The tap index rests at zero while idle and steps once per product.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tap_r <= '0;
        end else if (state_r == ST_IDLE) begin
            tap_r <= '0;
        end else if (state_r == ST_MAC) begin
            tap_r <= tap_r + 1'b1;
        end
    end

    // The accumulator clears on an accepted sample and adds one product per tap.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            acc_r <= '0;
        end else if (state_r == ST_IDLE && link.sample_we) begin
            acc_r <= '0;
        end else if (state_r == ST_MAC) begin
            acc_r <= acc_r + prod;
        end
    end

    // The bank flips after each result while swapping runs.
    // With swapping off the device is a plain FIR on bank zero, as one of a pair.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bank_r <= BANK_RESET;
        end else if (state_r == ST_IDLE && !link.swap_en) begin
            bank_r <= BANK_RESET;
        end else if (state_r == ST_DONE && swap_en_r) begin
            bank_r <= ~bank_r;
        end
    end

    // -----------------------------------------------------------------
    // Output selector
    // -----------------------------------------------------------------
    // Rounds a 24-bit window starting at the chosen bit, sign extended.
    always_comb begin
        logic signed [ACC_W:0] wide;
        wide = '0;
        case (sel_r)
            SEL_BIT7: wide = (ACC_W+1)'((acc_r + 36'sh40) >>> 7);
            SEL_BIT11: wide = (ACC_W+1)'((acc_r + 36'sh400) >>> 11);
            SEL_BIT15: wide = (ACC_W+1)'((acc_r + 36'sh4000) >>> 15);
            SEL_BIT20: wide = (ACC_W+1)'((acc_r + 36'sh80000) >>> 20);
            default: wide = '0;
        endcase
        rounded = wide[RESULT_W-1:0];
    end

    // -----------------------------------------------------------------
    // Result registers
    // -----------------------------------------------------------------
    // Result kind tracks the bank used in the publish cycle, so it alternates only while swapping runs.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            result_r <= '0;
            kind_r <= RES_FEEDBACK;
        end else if (state_r == ST_DONE) begin
            result_r <= rounded;
            kind_r <= bank_r;
        end
    end

    // Valid is set on publish and cleared by a read; publish wins a tie.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            valid_r <= 1'b0;
        end else if (state_r == ST_DONE) begin
            valid_r <= 1'b1;
        end else if (link.result_read) begin
            valid_r <= 1'b0;
        end
    end

    assign link.result_high_word = result_r[RESULT_W-1:HALF_W];
    assign link.result_low_word = result_r[HALF_W-1:0];
    assign link.result_valid = valid_r;
    assign link.result_kind = kind_r;
    assign link.busy = (state_r != ST_IDLE);
endmodule

// file: iir_host_seq.sv
`timescale 1ns/1ps

module iir_host_seq
    import iir_swap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cfg_we,
    input wire logic i_cfg_bank,
    input wire logic [TAP_IDX_W-1:0] i_cfg_addr,
    input wire logic [COEF_W-1:0] i_cfg_data,
    input wire logic i_run,
    input wire logic [1:0] i_out_sel,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [SAMPLE_W-1:0] i_in_data,
    output logic o_out_valid,
    output logic [RESULT_W-1:0] o_out_data,
    iir_link_if.host link
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_WRITE1,
        H_WAIT1,
        H_WRITE2,
        H_WAIT2
    } host_state_type;

    host_state_type state_r;
    logic [SAMPLE_W-1:0] diff_r;
    logic [SAMPLE_W-1:0] fb_r;
    logic fifo_valid;
    logic fifo_pop;
    logic [SAMPLE_W-1:0] fifo_data;
    logic [RESULT_W-1:0] res;
    logic out_valid_r;
    logic [RESULT_W-1:0] out_data_r;

    // -----------------------------------------------------------------
    // Input buffering
    // -----------------------------------------------------------------
    // Raw samples wait here while the device works on earlier ones.
    iir_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_in_valid),
        .o_in_ready(o_in_ready),
        .i_in_data(i_in_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    assign fifo_pop = (state_r == H_IDLE) && i_run && fifo_valid;
    assign res = {link.result_high_word, link.result_low_word};

    // -----------------------------------------------------------------
    // Two-pass sample sequencer
    // -----------------------------------------------------------------
    // Each raw sample is written twice: feedback pass, then output pass.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r <= H_IDLE;
            diff_r <= '0;
            fb_r <= '0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (fifo_pop) begin
                        diff_r <= fifo_data - fb_r;
                        state_r <= H_WRITE1;
                    end
                end
                H_WRITE1: begin
                    state_r <= H_WAIT1;
                end
                H_WAIT1: begin
                    if (link.result_valid && !link.busy) begin
                        fb_r <= res[SAMPLE_W-1:0];
                        state_r <= H_WRITE2;
                    end
                end
                H_WRITE2: begin
                    state_r <= H_WAIT2;
                end
                H_WAIT2: begin
                    if (link.result_valid && !link.busy) begin
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // Valid filter outputs are registered for the user side.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else begin
            out_valid_r <= 1'b0;
            if (state_r == H_WAIT2 && link.result_valid && !link.busy) begin
                out_valid_r <= 1'b1;
                out_data_r <= res;
            end
        end
    end

    // -----------------------------------------------------------------
    // Link drive
    // -----------------------------------------------------------------
    // Coefficient writes pass through only while i_run is low; the user keeps alternate taps zero.
    assign link.coef_we = i_cfg_we && !i_run;
    assign link.coef_bank = i_cfg_bank;
    assign link.coef_addr = i_cfg_addr;
    assign link.coef_data = i_cfg_data;
    assign link.swap_en = i_run;
    assign link.out_sel = i_out_sel;
    assign link.sample_we = (state_r == H_WRITE1) || (state_r == H_WRITE2);
    assign link.sample_data = diff_r;
    assign link.result_read = (state_r == H_WAIT1 || state_r == H_WAIT2)
        && link.result_valid && !link.busy;
    assign o_out_valid = out_valid_r;
    assign o_out_data = out_data_r;
endmodule

// file: iir_link_sva.sv
`timescale 1ns/1ps

module iir_link_sva
    import iir_swap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic sample_we,
    input wire logic swap_en,
    input wire logic busy,
    input wire logic result_valid,
    input wire logic result_read,
    input wire logic result_kind,
    input wire logic [HALF_W-1:0] result_high_word,
    input wire logic [HALF_W-1:0] result_low_word
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Remembers the kind of the previous result since reset.
    logic last_kind_r;
    logic seen_r;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            last_kind_r <= 1'b1;
            seen_r <= 1'b0;
        end else if (result_valid && !$past(result_valid)) begin
            last_kind_r <= result_kind;
            seen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence take_s;
        sample_we && !busy;
    endsequence

    sequence new_result_s;
        $rose(result_valid);
    endsequence

    chk_busy_after_take: assert property (take_s |=> (busy && !result_valid) [*8])
        else $error("device not busy after taking a sample");
    chk_answer_latency: assert property (take_s |-> ##34 $rose(result_valid))
        else $error("result not ready 34 cycles after sample write");
    chk_valid_stands: assert property (result_valid && !result_read |=> result_valid)
        else $error("result valid dropped before it was read");
    chk_result_read_clears: assert property (result_valid && result_read |=> !result_valid)
        else $error("result valid still high after read");
    chk_words_hold: assert property (result_valid && $past(result_valid)
        |-> $stable(result_high_word) && $stable(result_low_word))
        else $error("result words changed while held");
    chk_first_feedback: assert property (new_result_s and !seen_r
        |-> result_kind == 1'(RES_FEEDBACK))
        else $error("first result after reset is not a feedback term");
    chk_kind_alternates: assert property (new_result_s and seen_r && swap_en
        |-> result_kind != last_kind_r)
        else $error("result kind did not alternate");
    chk_host_waits_idle: assert property (sample_we |-> !busy)
        else $error("sample written while device busy");
    chk_host_reads_first: assert property (sample_we |-> !result_valid)
        else $error("sample written before result was read");
endmodule

// file: test_iir_bank_swap_sequencer.sv
`timescale 1ns/1ps

module test_iir_bank_swap_sequencer;
    import iir_swap_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_cfg_we = 1'b0;
    logic i_cfg_bank = 1'b0;
    logic [TAP_IDX_W-1:0] i_cfg_addr = '0;
    logic [COEF_W-1:0] i_cfg_data = '0;
    logic i_run = 1'b0;
    logic [1:0] i_out_sel = SEL_BIT15;
    logic i_in_valid = 1'b0;
    logic [SAMPLE_W-1:0] i_in_data = '0;
    logic o_in_ready;
    logic o_out_valid;
    logic [RESULT_W-1:0] o_out_data;
    logic saw_full = 1'b0;
    logic [RESULT_W-1:0] exp_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int n_out = 0;

    iir_link_if link();
    iir_mac_device u_iir_mac_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link));
    iir_host_seq u_iir_host_seq (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_we(i_cfg_we),
        .i_cfg_bank(i_cfg_bank), .i_cfg_addr(i_cfg_addr), .i_cfg_data(i_cfg_data),
        .i_run(i_run), .i_out_sel(i_out_sel), .i_in_valid(i_in_valid),
        .o_in_ready(o_in_ready), .i_in_data(i_in_data), .o_out_valid(o_out_valid),
        .o_out_data(o_out_data), .link(link));
    iir_link_sva u_iir_link_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .sample_we(link.sample_we), .swap_en(link.swap_en), .busy(link.busy),
        .result_valid(link.result_valid), .result_read(link.result_read),
        .result_kind(link.result_kind), .result_high_word(link.result_high_word),
        .result_low_word(link.result_low_word));

    // The clock toggles every half period of 2 ns.
    initial begin
        forever #2 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic give_up();
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
    endtask

    // Writes both banks: a at tap 0 of bank 0, b at tap 1 of bank 1, all else zero.
    task automatic load_banks(input logic [COEF_W-1:0] a0, input logic [COEF_W-1:0] b0);
        int t;
        i_cfg_we = 1'b1;
        for (t = 0; t < 2 * TAPS; t++) begin
            i_cfg_bank = t[0];
            i_cfg_addr = TAP_IDX_W'(t >> 1);
            i_cfg_data = (t == 0) ? a0 : ((t == 3) ? b0 : '0);
            step();
        end
        i_cfg_we = 1'b0;
        step();
    endtask

    // Holds a raw sample until the buffer takes it; a refusal is noted.
    task automatic push(input logic [SAMPLE_W-1:0] d);
        int k;
        i_in_valid = 1'b1;
        i_in_data = d;
        for (k = 0; k < 2000 && o_in_ready !== 1'b1; k++) begin
            saw_full = 1'b1;
            step();
        end
        if (k == 2000) give_up();
        step();
    endtask

    task automatic wait_outputs(input int n);
        int k;
        for (k = 0; k < 5000 && n_out < n; k++) step();
        if (k == 5000) give_up();
    endtask

    // Filtered outputs are compared in order against the expected queue.
    always @(negedge i_clk) begin
        if (o_out_valid === 1'b1) begin
            n_out++;
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected at %0t: output with none pending", $time);
            end else begin
                check(o_out_data, exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Pure feedforward gain of one half; a burst fills the buffer.
    task automatic test_stream();
        int k;
        logic [SAMPLE_W-1:0] x;
        load_banks(16'h0000, 16'h4000);
        i_run = 1'b1;
        for (k = 0; k < 12; k++) begin
            x = SAMPLE_W'(16'h0200 * (k + 1));
            exp_q.push_back({8'h00, 1'b0, x[15:1]});
            push(x);
        end
        i_in_valid = 1'b0;
        wait_outputs(12);
        check(RESULT_W'(saw_full), 24'h000001);
        i_run = 1'b0;
        step();
    endtask

    // Gain of one half through the other selector windows, with a negative
    // sample for sign extension and a half step and a quarter step for rounding.
    task automatic test_select();
        load_banks(16'h0000, 16'h4000);
        i_run = 1'b1;
        i_out_sel = SEL_BIT11;
        exp_q.push_back(24'h000800);
        exp_q.push_back(24'hfff800);
        push(16'h0100);
        push(16'hff00);
        i_in_valid = 1'b0;
        wait_outputs(14);
        i_out_sel = SEL_BIT7;
        exp_q.push_back(24'h008000);
        push(16'h0100);
        i_in_valid = 1'b0;
        wait_outputs(15);
        i_out_sel = SEL_BIT20;
        exp_q.push_back(24'h000005);
        exp_q.push_back(24'h000004);
        push(16'h0120);
        push(16'h0110);
        i_in_valid = 1'b0;
        wait_outputs(17);
        i_out_sel = SEL_BIT15;
        i_run = 1'b0;
        step();
    endtask

    // One-pole recursion: the stored feedback term is taken off each sample.
    task automatic test_recursive();
        int k;
        logic [SAMPLE_W-1:0] d;
        logic [SAMPLE_W-1:0] fb;
        load_banks(16'h4000, 16'h4000);
        i_run = 1'b1;
        fb = '0;
        for (k = 0; k < 4; k++) begin
            d = 16'h2000 - fb;
            fb = {1'b0, d[15:1]};
            exp_q.push_back({8'h00, fb});
            push(16'h2000);
        end
        i_in_valid = 1'b0;
        wait_outputs(21);
        check(RESULT_W'(exp_q.size()), 24'h000000);
        i_run = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    // Reset is held for eight cycles, then the scenarios run in turn.
    initial begin
        repeat (8) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        test_stream();
        test_select();
        test_recursive();
        close_out();
    end

    // Cuts the run short if it hangs.
    initial begin
        repeat (100000) @(posedge i_clk);
        give_up();
    end
endmodule
